// >>> tpm_top.sv
// Timer 0/1 mode control with AXI4-Lite register access.
// Assumes pins asynchronous to CORE_CLK; prescale tick comes from core logic.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module tpm_top
    import tpm_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic      [1:0]  S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic      [31:0] S_AXI_RDATA,
    output logic      [1:0]  S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        PRESC_TICK0,
    input  wire logic        PRESC_TICK1,
    input  wire logic        EXT_IRQ0_INPUT,
    input  wire logic        EXT_IRQ1_INPUT,
    input  wire logic        TIMER0_COUNT_PIN,
    input  wire logic        TIMER1_COUNT_PIN,
    output logic             TIMER0_OVF,
    output logic             TIMER1_OVF
);
    logic [1:0]  rst_sync_q;
    logic        rst_n;
    logic [1:0]  irq0_s_q;
    logic [1:0]  irq1_s_q;
    logic [1:0]  pin0_s_q;
    logic [1:0]  pin1_s_q;
    logic [7:0]  timer_pair_mode_reg_q;
    logic [23:0] ctrl_q;
    logic        aw_q;
    logic        w_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [15:0] count0;
    logic [15:0] count1;
    logic        do_write;
    logic [31:0] mode_merged;
    logic [31:0] ctrl_merged;

    // Byte-lane merge used by both writable registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // A function result cannot be sliced in place, so the merge lands on a net first
    assign mode_merged = merge({24'h000000, timer_pair_mode_reg_q}, wdata_q, wstrb_q);
    assign ctrl_merged = merge({8'h00, ctrl_q}, wdata_q, wstrb_q);

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Pins are asynchronous: two stages before the counters look at them
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq0_s_q <= 2'b00;
            irq1_s_q <= 2'b00;
            pin0_s_q <= 2'b00;
            pin1_s_q <= 2'b00;
        end else begin
            irq0_s_q <= {irq0_s_q[0], EXT_IRQ0_INPUT};
            irq1_s_q <= {irq1_s_q[0], EXT_IRQ1_INPUT};
            pin0_s_q <= {pin0_s_q[0], TIMER0_COUNT_PIN};
            pin1_s_q <= {pin1_s_q[0], TIMER1_COUNT_PIN};
        end
    end

    // Write channel: address and data taken in either order, then one response
    assign S_AXI_AWREADY = !aw_q && !bvalid_q;
    assign S_AXI_WREADY  = !w_q && !bvalid_q;
    assign do_write      = aw_q && w_q && !bvalid_q;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= TPM_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_q     <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_q     <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end
            if (do_write) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (awaddr_q == TPM_ADDR_MODE || awaddr_q == TPM_ADDR_CTRL)
                            ? TPM_RESP_OKAY : TPM_RESP_SLVERR;
            end else if (bvalid_q && S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP  = bresp_q;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            timer_pair_mode_reg_q <= TPM_MODE_RESET;                        // RULE_13
            ctrl_q                <= 24'h000000;
        end else if (do_write) begin
            if (awaddr_q == TPM_ADDR_MODE) begin
                timer_pair_mode_reg_q <= mode_merged[7:0];                  // RULE_13
            end
            if (awaddr_q == TPM_ADDR_CTRL) begin
                ctrl_q <= ctrl_merged[23:0];
            end
        end
    end

    // Read channel: one cycle from address to data
    assign S_AXI_ARREADY = !rvalid_q;
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= TPM_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_q <= 1'b1;
            rresp_q  <= TPM_RESP_OKAY;
            case (S_AXI_ARADDR)
                TPM_ADDR_MODE:  rdata_q <= {24'h000000, timer_pair_mode_reg_q}; // RULE_13
                TPM_ADDR_CTRL:  rdata_q <= {8'h00, ctrl_q};
                TPM_ADDR_T0CNT: rdata_q <= {16'h0000, count0};
                TPM_ADDR_T1CNT: rdata_q <= {16'h0000, count1};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= TPM_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA  = rdata_q;
    assign S_AXI_RRESP  = rresp_q;

    tpm_counter u_timer0 (
        .clk        (CORE_CLK),
        .rst_n      (rst_n),
        .run        (ctrl_q[TPM_C_RUN0]),
        .gate_sel   (timer_pair_mode_reg_q[TPM_TMR0_GATE_BIT]),            // RULE_07 RULE_08
        .src_sel    (timer_pair_mode_reg_q[TPM_TMR0_SRC_BIT]),             // RULE_09 RULE_10
        .mode       (timer_pair_mode_reg_q[TPM_TMR0_MODE_LSB +: 2]),       // RULE_11
        .irq_level  (irq0_s_q[1]),
        .irq_pol    (ctrl_q[TPM_C_POL0]),
        .presc_tick (PRESC_TICK0),
        .pin_level  (pin0_s_q[1]),
        .reload     (ctrl_q[TPM_C_RLD_LSB +: 8]),
        .count_q    (count0),
        .ovf_q      (TIMER0_OVF)
    );

    tpm_counter u_timer1 (
        .clk        (CORE_CLK),
        .rst_n      (rst_n),
        .run        (ctrl_q[TPM_C_RUN1]),
        .gate_sel   (timer_pair_mode_reg_q[TPM_TMR1_GATE_BIT]),            // RULE_01 RULE_02
        .src_sel    (timer_pair_mode_reg_q[TPM_TMR1_SRC_BIT]),             // RULE_03 RULE_04
        .mode       (timer_pair_mode_reg_q[TPM_TMR1_MODE_LSB +: 2]),       // RULE_05 RULE_06
        .irq_level  (irq1_s_q[1]),
        .irq_pol    (ctrl_q[TPM_C_POL1]),
        .presc_tick (PRESC_TICK1),
        .pin_level  (pin1_s_q[1]),
        .reload     (ctrl_q[TPM_C_RLD1_LSB +: 8]),
        .count_q    (count1),
        .ovf_q      (TIMER1_OVF)
    );
endmodule : tpm_top
`default_nettype wire

// >>> tpm_pkg.sv
// Constants for the timer 0/1 mode control block: register map and field layout.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
//
// Summary of operation
// [RULE_01] Gate off: timer 1 counts when run set
// [RULE_02] Gate on: timer 1 also needs active irq1
// [RULE_03] Source 0: timer 1 counts prescaled clock
// [RULE_04] Source 1: timer 1 counts pin falling edges
// [RULE_05] Timer 1 mode: 13, 16, 8 bit
// [RULE_06] Timer 1 mode 11: never counts
// [RULE_07] Gate off: timer 0 counts when run set
// [RULE_08] Gate on: timer 0 also needs active irq0
// [RULE_09] Source 0: timer 0 counts prescaled clock
// [RULE_10] Source 1: timer 0 counts pin falling edges
// [RULE_11] Timer 0 mode: 13, 16, 8 bit
// [RULE_12] 8-bit mode reloads from reload byte
// [RULE_13] Mode register read/write, resets to zero
package tpm_pkg;
    localparam logic [7:0] TPM_ADDR_MODE   = 8'h00;
    localparam logic [7:0] TPM_ADDR_CTRL   = 8'h04;
    localparam logic [7:0] TPM_ADDR_T0CNT  = 8'h08;
    localparam logic [7:0] TPM_ADDR_T1CNT  = 8'h0C;
    localparam logic [7:0] TPM_MODE_RESET  = 8'h00;
    localparam int         TPM_TMR1_GATE_BIT = 7;
    localparam int         TPM_TMR1_SRC_BIT  = 6;
    localparam int         TPM_TMR1_MODE_LSB = 4;
    localparam int         TPM_TMR0_GATE_BIT = 3;
    localparam int         TPM_TMR0_SRC_BIT  = 2;
    localparam int         TPM_TMR0_MODE_LSB = 0;
    // Control register bits
    localparam int         TPM_C_RUN0      = 0;
    localparam int         TPM_C_RUN1      = 1;
    localparam int         TPM_C_POL0      = 2;
    localparam int         TPM_C_POL1      = 3;
    localparam int         TPM_C_RLD_LSB   = 8;
    localparam int         TPM_C_RLD1_LSB  = 16;
    localparam logic [1:0] TPM_RESP_OKAY   = 2'b00;
    localparam logic [1:0] TPM_RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        TPM_MODE_13   = 2'b00,
        TPM_MODE_16   = 2'b01,
        TPM_MODE_8RLD = 2'b10,
        TPM_MODE_OFF  = 2'b11
    } tpm_mode_t;
endpackage : tpm_pkg

// >>> tpm_counter.sv
// One counter/timer: gating, source choice, width mode and auto-reload.
// Assumes synchronised inputs on the same clock as the counter.
`timescale 1ns/100ps
`default_nettype none
module tpm_counter
    import tpm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic        gate_sel,
    input  wire logic        src_sel,
    input  wire logic [1:0]  mode,
    input  wire logic        irq_level,
    input  wire logic        irq_pol,
    input  wire logic        presc_tick,
    input  wire logic        pin_level,
    input  wire logic [7:0]  reload,
    output logic      [15:0] count_q,
    output logic             ovf_q
);
    logic pin_prev_q;
    logic enable;
    logic tick;
    logic fall;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_level;
        end
    end

    assign fall   = pin_prev_q & ~pin_level;                                // RULE_04 RULE_10
    // Gate qualifies run; polarity flips the irq level
    assign enable = run & (~gate_sel | (irq_level ~^ irq_pol));             // RULE_01 RULE_02 RULE_07 RULE_08
    assign tick   = enable & (src_sel ? fall : presc_tick)                  // RULE_03 RULE_09
                  & (tpm_mode_t'(mode) != TPM_MODE_OFF);                    // RULE_06

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 16'h0000;
            ovf_q   <= 1'b0;
        end else begin
            ovf_q <= 1'b0;
            if (tick) begin
                case (tpm_mode_t'(mode))                                    // RULE_05 RULE_11
                    TPM_MODE_13: begin
                        if (count_q[12:0] == 13'h1FFF) begin
                            count_q <= 16'h0000;
                            ovf_q   <= 1'b1;
                        end else begin
                            count_q <= {3'b000, count_q[12:0] + 13'h0001};
                        end
                    end
                    TPM_MODE_16: begin
                        count_q <= count_q + 16'h0001;
                        ovf_q   <= (count_q == 16'hFFFF);
                    end
                    TPM_MODE_8RLD: begin
                        if (count_q[7:0] == 8'hFF) begin
                            count_q <= {8'h00, reload};                     // RULE_12
                            ovf_q   <= 1'b1;
                        end else begin
                            count_q <= {8'h00, count_q[7:0] + 8'h01};
                        end
                    end
                    default: begin
                        count_q <= count_q;
                    end
                endcase
            end
        end
    end
endmodule : tpm_counter
`default_nettype wire

// >>> tpm_monitor.sv
// Checker for the timer mode block: register bus handshakes and responses.
// Sees only top-level ports; bound into tpm_top after the module.
`timescale 1ns/100ps
`default_nettype none
module tpm_monitor (
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_wr_take;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_rd_take;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    // Both halves are registered first, so the response is two edges after the take
    a_write_answer: assert property (s_wr_take |-> ##2 S_AXI_BVALID)
        else $error("write response missing");
    a_read_answer: assert property (s_rd_take |=> S_AXI_RVALID)
        else $error("read response missing");
    a_bvalid_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped early");
    a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data not held");
    a_bvalid_ends: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write response repeated");
    a_rvalid_ends: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("read response repeated");
    a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address taken while busy");
    a_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while busy");
endmodule : tpm_monitor
bind tpm_top tpm_monitor u_mon (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY)
);
`default_nettype wire

// >>> tb.sv
// Self-checking bench for tpm_top: register access and timer counting.
// Drives the AXI4-Lite port, prescale ticks, irq levels and count pins.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import tpm_pkg::*;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        tick0, tick1, irq0, irq1, pin0, pin1;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        ovf0, ovf1;
    int          err_count, checks_done;
    int          ovf0_n, ovf1_n;
    tpm_top uut (
        .CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .PRESC_TICK0(tick0), .PRESC_TICK1(tick1), .EXT_IRQ0_INPUT(irq0),
        .EXT_IRQ1_INPUT(irq1), .TIMER0_COUNT_PIN(pin0), .TIMER1_COUNT_PIN(pin1),
        .TIMER0_OVF(ovf0), .TIMER1_OVF(ovf1)
    );
    // Overflow pulses last one cycle, so they are tallied at every edge
    always @(posedge clk) begin
        if (ovf0 === 1'b1) ovf0_n <= ovf0_n + 1;
        if (ovf1 === 1'b1) ovf1_n <= ovf1_n + 1;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        // Local flags: the valid strobes themselves only settle after this time step
        logic aw_done = 1'b0;
        logic w_done  = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready  <= 1'b0;
        chk(rdata & m, e);
        chk(rresp, er);
    endtask : rd
    // Both timers see the same ticks so one pass checks each against its own mode
    task automatic tk(input int n);
        repeat (n) begin
            tick0 <= 1'b1;
            tick1 <= 1'b1;
            @(posedge clk);
            tick0 <= 1'b0;
            tick1 <= 1'b0;
            @(posedge clk);
        end
    endtask : tk
    // Pins are synchronised, so each level is held well past the two-flop delay
    task automatic pn(input int n);
        repeat (n) begin
            pin0 <= 1'b0;
            pin1 <= 1'b0;
            repeat (4) @(posedge clk);
            pin0 <= 1'b1;
            pin1 <= 1'b1;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask : pn
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {tick0, tick1, pin0, pin1, irq0, irq1} = 6'h0F;
        {awaddr, araddr, wdata} = '0;
        err_count = 0;
        checks_done = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(TPM_ADDR_MODE, 32'hFF, 32'h0, TPM_RESP_OKAY);
        wr(TPM_ADDR_MODE, 32'hFF, TPM_RESP_OKAY);
        rd(TPM_ADDR_MODE, 32'hFF, 32'hFF, TPM_RESP_OKAY);
        wr(8'h10, 32'h5, TPM_RESP_SLVERR);
        rd(8'h10, 32'hFFFFFFFF, 32'h0, TPM_RESP_SLVERR);
        wr(TPM_ADDR_T0CNT, 32'h1, TPM_RESP_SLVERR);
        $display("register test done");
        // Both running, irq active low, reload bytes FE and FD
        wr(TPM_ADDR_CTRL, 32'h00FDFE03, TPM_RESP_OKAY);
        wr(TPM_ADDR_MODE, 32'h31, TPM_RESP_OKAY);
        tk(5);
        rd(TPM_ADDR_T0CNT, 32'hFFFF, 32'h5, TPM_RESP_OKAY);
        rd(TPM_ADDR_T1CNT, 32'hFFFF, 32'h0, TPM_RESP_OKAY);
        wr(TPM_ADDR_MODE, 32'h99, TPM_RESP_OKAY);
        tk(5);
        rd(TPM_ADDR_T0CNT, 32'hFFFF, 32'h5, TPM_RESP_OKAY);
        rd(TPM_ADDR_T1CNT, 32'hFFFF, 32'h0, TPM_RESP_OKAY);
        irq0 <= 1'b0;
        irq1 <= 1'b0;
        repeat (4) @(posedge clk);
        tk(3);
        rd(TPM_ADDR_T0CNT, 32'hFFFF, 32'h8, TPM_RESP_OKAY);
        rd(TPM_ADDR_T1CNT, 32'hFFFF, 32'h3, TPM_RESP_OKAY);
        $display("gate test done");
        irq1 <= 1'b1;
        wr(TPM_ADDR_MODE, 32'h15, TPM_RESP_OKAY);
        tk(2);
        pn(4);
        rd(TPM_ADDR_T0CNT, 32'hFFFF, 32'hC, TPM_RESP_OKAY);
        rd(TPM_ADDR_T1CNT, 32'hFFFF, 32'h5, TPM_RESP_OKAY);
        wr(TPM_ADDR_MODE, 32'h51, TPM_RESP_OKAY);
        tk(1);
        pn(2);
        rd(TPM_ADDR_T0CNT, 32'hFFFF, 32'hD, TPM_RESP_OKAY);
        rd(TPM_ADDR_T1CNT, 32'hFFFF, 32'h7, TPM_RESP_OKAY);
        $display("source test done");
        wr(TPM_ADDR_MODE, 32'h22, TPM_RESP_OKAY);
        tk(243);
        rd(TPM_ADDR_T0CNT, 32'hFF, 32'hFE, TPM_RESP_OKAY);
        rd(TPM_ADDR_T1CNT, 32'hFF, 32'hFA, TPM_RESP_OKAY);
        tk(6);
        rd(TPM_ADDR_T0CNT, 32'hFF, 32'hFE, TPM_RESP_OKAY);
        rd(TPM_ADDR_T1CNT, 32'hFF, 32'hFD, TPM_RESP_OKAY);
        chk(ovf0_n, 32'd4);
        chk(ovf1_n, 32'd1);
        $display("reload test done");
        // 13-bit mode from FE and FD: a tick every cycle carries both past 1FFF
        wr(TPM_ADDR_MODE, 32'h00, TPM_RESP_OKAY);
        tick0 <= 1'b1;
        tick1 <= 1'b1;
        repeat (7940) @(posedge clk);
        tick0 <= 1'b0;
        tick1 <= 1'b0;
        rd(TPM_ADDR_T0CNT, 32'hFFFF, 32'h2, TPM_RESP_OKAY);
        rd(TPM_ADDR_T1CNT, 32'hFFFF, 32'h1, TPM_RESP_OKAY);
        chk(ovf0_n, 32'd5);
        chk(ovf1_n, 32'd2);
        $display("width test done");
        summarize();
    end
endmodule : tb
`default_nettype wire
